// ==== shared/pic_pkg.sv ====
// Package of the prioritized interrupt controller: register map,
// reset values, carrier types and shared decode functions.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`default_nettype none

package pic_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NSRC   = 32;
   localparam int IDW    = 5;
   localparam int PRIO_W = 8;
   localparam int ARB_W  = 3;
   localparam int NLVL   = 8;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_EN_SET = 8'h00;
   localparam logic [7:0] OFS_EN_CLR = 8'h04;
   localparam logic [7:0] OFS_PEND   = 8'h08;
   localparam logic [7:0] OFS_GROUP  = 8'h0C;
   localparam logic [7:0] OFS_GMASK  = 8'h10;
   localparam logic [7:0] OFS_ACTIVE = 8'h14;
   localparam logic [7:0] OFS_PRIO   = 8'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ACT_ID_LSB  = 8;
   localparam int ACT_REQ_BIT = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [NSRC-1:0]   EN_RST    = 32'h0000_0000;
   localparam logic [PRIO_W-1:0] PRIO_RST  = 8'h00;
   localparam logic [2:0]        GROUP_RST = 3'h0;
   localparam logic              GMASK_RST = 1'h0;
   localparam logic [NLVL-1:0]   ACT_RST   = 8'h00;
   localparam logic [2:0]        ARB_BITS  = 3'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic [IDW-1:0]    id;
      logic [PRIO_W-1:0] prio;
   } pic_req_t;

   typedef enum logic [0:0] {
      PIC_BUS_IDLE = 1'b0,
      PIC_BUS_ACK  = 1'b1
   } pic_bus_t;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Mask of arbitration bits that count as preemption bits
   function automatic logic [ARB_W-1:0] pic_gmask(input logic [2:0] grp);
      logic [2:0] n;
      n = (grp >= ARB_BITS) ? ARB_BITS : grp;
      return ~(3'h7 >> n);
   endfunction

   // Lowest set level of the active map, NLVL when none is active
   function automatic logic [3:0] pic_low_lvl(input logic [NLVL-1:0] m);
      logic [3:0] r;
      r = 4'h8;
      for (int i = NLVL - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

endpackage

`default_nettype wire

// ==== logic/pic_arbiter.sv ====
// Combinational arbiter: picks the pending source with the smallest
// arbitration level, the lower source number on a tie.
// Assumes the caller registers its outputs.
`timescale 1ns/1ps
`default_nettype none

module pic_arbiter
   import pic_pkg::*;
(
   // Candidates
   input  wire logic [NSRC-1:0]           pend_i,
   input  wire logic [NSRC-1:0][ARB_W-1:0] lvl_i,
   // Winner
   output logic                           found_o,
   output logic [IDW-1:0]                 id_o,
   output logic [ARB_W-1:0]               lvl_o
);

   // -------------------------------------------------------------------
   // Scan
   // -------------------------------------------------------------------
   // Scanning downward with <= lets the lowest number win ties
   always_comb begin
      found_o = 1'b0;
      id_o    = '0;
      lvl_o   = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend_i[i] && (!found_o || lvl_i[i] <= lvl_o)) begin
            found_o = 1'b1;
            id_o    = IDW'(i);
            lvl_o   = lvl_i[i];
         end
      end
   end

endmodule

`default_nettype wire

// ==== logic/pic_top.sv ====
// Prioritized interrupt controller: per-source enables and priorities,
// preemption grouping, arbitration and nesting of active handlers.
// Assumes sources and the core share clk_sys_i; registers on Wishbone.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module pic_top
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Interrupt sources
   input  wire logic [NSRC-1:0] src_irq_i,
   // Core side
   output pic_req_t         irq_o,
   input  wire logic        irq_ack_i,
   input  wire logic        irq_eoi_i
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [NSRC-1:0]              enable,  next_enable;
   logic [NSRC-1:0][PRIO_W-1:0]  prio,    next_prio;
   logic [2:0]                   grp,     next_grp;
   logic                         gmask,   next_gmask;
   pic_bus_t                     bus_st,  next_bus_st;
   logic [31:0]                  rdata,   next_rdata;
   logic [NLVL-1:0]              act_map, next_act_map;
   pic_req_t                     irq_q,   next_irq_q;

   logic                         req_new;
   logic                         wr;
   logic [NSRC-1:0]              pend;
   logic [NSRC-1:0][ARB_W-1:0]   arb_lvl;
   logic                         win_found;
   logic [IDW-1:0]               win_id;
   logic [ARB_W-1:0]             win_lvl;
   logic [ARB_W-1:0]             grp_bits;
   logic [3:0]                   act_lvl;

   assign req_new  = wb_cyc_i && wb_stb_i && (bus_st == PIC_BUS_IDLE);
   assign wr       = req_new && wb_we_i;
   assign grp_bits = pic_gmask(grp);
   assign act_lvl  = pic_low_lvl(act_map);
   assign wb_ack_o = (bus_st == PIC_BUS_ACK);
   assign wb_dat_o = rdata;
   assign irq_o    = irq_q;

   // -------------------------------------------------------------------
   // Arbitration
   // -------------------------------------------------------------------
   // The global mask gates the pending set, never the enables
   assign pend = src_irq_i & enable & ~{NSRC{gmask}};

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         arb_lvl[i] = prio[i][PRIO_W-1 -: ARB_W];
      end
   end

   pic_arbiter u_arb (
      .pend_i  (pend),
      .lvl_i   (arb_lvl),
      .found_o (win_found),
      .id_o    (win_id),
      .lvl_o   (win_lvl)
   );

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always_comb begin
      next_enable = enable;
      next_prio   = prio;
      next_grp    = grp;
      next_gmask  = gmask;
      if (wr) begin
         case (wb_adr_i)
            OFS_EN_SET: begin
               next_enable = enable | wb_dat_i;
            end
            OFS_EN_CLR: begin
               next_enable = enable & ~wb_dat_i;
            end
            OFS_GROUP: begin
               if (wb_sel_i[0]) begin
                  next_grp = wb_dat_i[2:0];
               end
            end
            OFS_GMASK: begin
               if (wb_sel_i[0]) begin
                  next_gmask = wb_dat_i[0];
               end
            end
            default: begin
               if (wb_adr_i[7:5] == OFS_PRIO[7:5]) begin
                  for (int b = 0; b < 4; b++) begin
                     if (wb_sel_i[b]) begin
                        next_prio[{wb_adr_i[4:2], 2'(b)}] =
                           wb_dat_i[8*b +: 8];
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enable <= EN_RST;
         prio   <= {NSRC{PRIO_RST}};
         grp    <= GROUP_RST;
         gmask  <= GMASK_RST;
      end else begin
         enable <= next_enable;
         prio   <= next_prio;
         grp    <= next_grp;
         gmask  <= next_gmask;
      end
   end

   // -------------------------------------------------------------------
   // Bus answer
   // -------------------------------------------------------------------
   // Unmapped reads answer zero; the ack is never withheld
   always_comb begin
      next_bus_st = req_new ? PIC_BUS_ACK : PIC_BUS_IDLE;
      next_rdata  = rdata;
      if (req_new) begin
         next_rdata = '0;
         case (wb_adr_i)
            OFS_EN_SET, OFS_EN_CLR: next_rdata = enable;
            OFS_PEND:   next_rdata = src_irq_i;
            OFS_GROUP:  next_rdata = {29'h0, grp};
            OFS_GMASK:  next_rdata = {31'h0, gmask};
            OFS_ACTIVE: begin
               next_rdata[NLVL-1:0]                 = act_map;
               next_rdata[ACT_ID_LSB +: IDW]         = irq_q.id;
               next_rdata[ACT_REQ_BIT]              = irq_q.valid;
            end
            default: begin
               if (wb_adr_i[7:5] == OFS_PRIO[7:5]) begin
                  for (int b = 0; b < 4; b++) begin
                     next_rdata[8*b +: 8] =
                        prio[{wb_adr_i[4:2], 2'(b)}];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_st <= PIC_BUS_IDLE;
         rdata  <= 32'h0000_0000;
      end else begin
         bus_st <= next_bus_st;
         rdata  <= next_rdata;
      end
   end

   // -------------------------------------------------------------------
   // Presentation and nesting
   // -------------------------------------------------------------------
   // One bit per preemption level in service; levels nest strictly,
   // so the lowest set bit is the running handler
   always_comb begin
      next_act_map = act_map;
      if (irq_eoi_i) begin
         next_act_map = act_map & (act_map - 8'h01);
      end
      if (irq_ack_i && irq_q.valid) begin
         next_act_map[irq_q.prio[PRIO_W-1 -: ARB_W] & grp_bits] = 1'b1;
      end
      next_irq_q.id    = win_id;
      next_irq_q.prio  = prio[win_id];
      // Dropped in the ack cycle so a taken request is not offered twice
      next_irq_q.valid = win_found && !irq_ack_i &&
         ({1'b0, win_lvl & grp_bits} < act_lvl);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_map <= ACT_RST;
         irq_q   <= '0;
      end else begin
         act_map <= next_act_map;
         irq_q   <= next_irq_q;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   logic [NSRC-1:0] pend_d;
   logic [ARB_W-1:0] grp_bits_d;
   logic [3:0]       act_lvl_d;
   logic            best_ok;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_d     <= '0;
         grp_bits_d <= '0;
         act_lvl_d  <= 4'h8;
      end else begin
         pend_d     <= pend;
         grp_bits_d <= grp_bits;
         act_lvl_d  <= act_lvl;
      end
   end

   always_comb begin
      best_ok = 1'b1;
      for (int i = 0; i < NSRC; i++) begin
         if (pend_d[i] &&
             ((prio[i][7:5] < irq_q.prio[7:5]) ||
              (prio[i][7:5] == irq_q.prio[7:5] && IDW'(i) < irq_q.id))) begin
            best_ok = 1'b0;
         end
      end
   end

   default clocking chk_cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   en_gate_a: assert property (irq_q.valid |-> pend_d[irq_q.id])
      else $error("presented source was not enabled and pending");

   en_keep_a: assert property (
      (wr && wb_adr_i == OFS_EN_SET) |=>
         ((enable & ~$past(wb_dat_i)) == ($past(enable) & ~$past(wb_dat_i)))
         && ((enable & $past(wb_dat_i)) == $past(wb_dat_i)))
      else $error("enable set disturbed other bits");

   prio_back_a: assert property (
      (wr && wb_adr_i == OFS_PRIO && wb_sel_i[0]) |=>
         prio[0] == $past(wb_dat_i[7:0]))
      else $error("priority write not stored");

   grp_store_a: assert property (
      (wr && wb_adr_i == OFS_GROUP && wb_sel_i[0]) |=>
         grp == $past(wb_dat_i[2:0]))
      else $error("grouping write not stored");

   grp_back_a: assert property (
      (req_new && !wb_we_i && wb_adr_i == OFS_GROUP) |=>
         (wb_ack_o && wb_dat_o == {29'h0, $past(grp)}))
      else $error("grouping read back differs");

   grp_sat_a: assert property (grp >= 3'h3 |-> grp_bits == 3'h7)
      else $error("grouping above three changes arbitration");

   // A priority written in the cycle before is not yet seen by irq_q
   best_win_a: assert property (irq_q.valid && !$past(wr) |-> best_ok)
      else $error("presented source is not the most urgent");

   gmask_keep_a: assert property (gmask ##1 gmask |-> !irq_q.valid)
      else $error("request presented under global mask");

   no_preempt_a: assert property (irq_q.valid |->
      ({1'b0, irq_q.prio[7:5] & grp_bits_d} < act_lvl_d))
      else $error("request does not preempt the active level");

   rst_val_a: assert property (
      $rose(rst_n_i) |-> (enable == '0 && grp == '0 && prio[0] == '0))
      else $error("state not cleared by reset");

   bus_ack_a: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");

endmodule

`default_nettype wire

// ==== verification/pic_core_model.sv ====
// Core model: takes presented requests and ends handlers when told.
// Assumes the controller's core port and the same clock.
`timescale 1ns/1ps
`default_nettype none

module pic_core_model
   import pic_pkg::*;
(
   // Clock and reset
   input  wire logic           clk_sys_i,
   input  wire logic           rst_n_i,
   // Controller side
   input  wire pic_req_t       irq_i,
   output logic                ack_o,
   output logic                eoi_o,
   // Bench control
   input  wire logic           take_i,
   input  wire logic [1:0]     dly_i,
   input  wire logic           eoi_req_i,
   output logic [IDW-1:0]      id_o
);
   logic [1:0] wait_cnt;

   // Slow answers hold valid for dly_i extra cycles before taking it
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o    <= 1'b0;
         eoi_o    <= 1'b0;
         wait_cnt <= 2'h0;
         id_o     <= '0;
      end else begin
         ack_o <= 1'b0;
         eoi_o <= eoi_req_i;
         if (take_i && irq_i.valid && !ack_o) begin
            if (wait_cnt == dly_i) begin
               ack_o    <= 1'b1;
               id_o     <= irq_i.id;
               wait_cnt <= 2'h0;
            end else begin
               wait_cnt <= wait_cnt + 2'h1;
            end
         end else begin
            wait_cnt <= 2'h0;
         end
      end
   end
endmodule

`default_nettype wire

// ==== verification/pic_top_tb.sv ====
// Self-checking bench of the interrupt controller, random and corners.
// Assumes pic_top and the core model on one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module pic_top_tb
   import pic_pkg::*;
;
   logic           clk, rst_n, cyc, stb, we, ack, take, eoi_req;
   logic           c_ack, c_eoi;
   logic [7:0]     adr;
   logic [31:0]    wdat, rdat, src, lfsr_q, en, v;
   logic [1:0]     dly;
   logic [3:0]     sel;
   logic [IDW-1:0] tid;
   logic [31:0]    pw [8];
   pic_req_t       irq;
   int             failures, total_checks;

   pic_top i_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .src_irq_i(src), .irq_o(irq), .irq_ack_i(c_ack),
      .irq_eoi_i(c_eoi));

   pic_core_model i_core (.clk_sys_i(clk), .rst_n_i(rst_n), .irq_i(irq),
      .ack_o(c_ack), .eoi_o(c_eoi), .take_i(take), .dly_i(dly),
      .eoi_req_i(eoi_req), .id_o(tid));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1]
                ^ lfsr_q[0]};
      return lfsr_q;
   endfunction

   function automatic logic [2:0] lvl(input int s);
      return pw[s / 4][8 * (s % 4) + 5 +: 3];
   endfunction

   // Expected winner: {found, id}, lower id wins a tie
   function automatic logic [5:0] best(input logic [31:0] p);
      logic [5:0] r;
      r = 6'h00;
      for (int s = 31; s >= 0; s--) begin
         if (p[s] && (!r[5] || lvl(s) <= lvl(int'(r[4:0])))) begin
            r = {1'b1, 5'(s)};
         end
      end
      return r;
   endfunction

   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         failures++;
         finish_test();
      end
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(q, e, "register read");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic irq_chk(input logic [5:0] e);
      logic [7:0] pr;
      repeat (3) @(posedge clk);
      chk(32'({irq.valid, irq.id & {5{irq.valid}}}), 32'(e), "presented");
      if (e[5]) begin
         pr = pw[e[4:0] / 4][8 * (e[4:0] % 4) +: 8];
         chk(32'(irq.prio), 32'(pr), "presented priority");
      end
   endtask

   task automatic eoi_pulse;
      eoi_req <= 1'b1;
      @(posedge clk);
      eoi_req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      {rst_n, cyc, stb, we, take, eoi_req} = '0;
      {adr, wdat, src, dly} = '0;
      sel = 4'hF;
      lfsr_q = 32'h0000_0007;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(OFS_EN_SET, 32'h0000_0000);
      rd_chk(OFS_GROUP, 32'h0000_0000);
      rd_chk(8'h40, 32'h0000_0000);
      for (int k = 0; k < 8; k++) begin
         rd_chk(OFS_PRIO + 8'(4 * k), 32'h0000_0000);
         pw[k] = rnd();
         wr(OFS_PRIO + 8'(4 * k), pw[k]);
         rd_chk(OFS_PRIO + 8'(4 * k), pw[k]);
      end
      // Single byte lane write must leave the other lanes alone
      sel <= 4'h2;
      wr(OFS_PRIO + 8'h04, 32'hFFFF_A5FF);
      sel <= 4'hF;
      pw[1][15:8] = 8'hA5;
      rd_chk(OFS_PRIO + 8'h04, pw[1]);
      // Set and clear pass through separate ports; model tracks both
      v = rnd();
      wr(OFS_EN_SET, v);
      en = rnd();
      wr(OFS_EN_CLR, en);
      en = v & ~en;
      rd_chk(OFS_EN_SET, en);
      for (int t = 0; t < 14; t++) begin
         src <= (t == 0) ? ~en : rnd();
         irq_chk(best(((t == 0) ? ~en : lfsr_q) & en));
         rd_chk(OFS_PEND, src);
      end
      wr(OFS_GMASK, 32'h0000_0001);
      src <= en;
      irq_chk(6'h00);
      rd_chk(OFS_EN_SET, en);
      wr(OFS_GMASK, 32'h0000_0000);
      src <= 32'h0000_0000;
      wr(OFS_EN_CLR, 32'hFFFF_FFFF);
      wr(OFS_EN_SET, 32'h0000_0014);
      pw[0] = 32'h0020_0000;
      pw[1] = 32'h0000_0060;
      wr(OFS_PRIO, pw[0]);
      wr(OFS_PRIO + 8'h04, pw[1]);
      // Source 4 active, source 2 differs only from preemption bit 6 on
      for (int g = 0; g < 8; g++) begin
         wr(OFS_GROUP, 32'(g));
         if (g <= 3) rd_chk(OFS_GROUP, 32'(g));
         dly  <= 2'(rnd());
         src  <= 32'h0000_0010;
         take <= 1'b1;
         repeat (9) @(posedge clk);
         take <= 1'b0;
         chk(32'(tid), 32'h0000_0004, "taken id");
         rd_chk(OFS_ACTIVE, 32'h0000_0400 |
            (32'h1 << ((g >= 3) ? 3 : (g == 2) ? 2 : 0)));
         src <= 32'h0000_0004;
         irq_chk((g >= 2) ? 6'h22 : 6'h00);
         eoi_pulse();
         irq_chk(6'h22);
         take <= 1'b1;
         repeat (9) @(posedge clk);
         take <= 1'b0;
         chk(32'(tid), 32'h0000_0002, "taken id");
         src  <= 32'h0000_0000;
         eoi_pulse();
      end
      finish_test();
   end
endmodule

`default_nettype wire
